// >>> hdl/vmic_pkg.sv
// Constants for the velocity monitor and switching I/O configuration block
// Function
// - Config bit 0: violate above or below limit
// - Config bit 1: both directions or configured direction
// - Config bit 2 enables dynamic monitor; rest reserved
// - Status bit 0 flags faulty velocity measurement
// - Status bit 2 set for negative direction
// - Status bits 3-7 flag monitor violations
// - Status bits 8-12 show comparison active
// - I/O config bit 0: input clear, output set
// - Input bit 1: falling or rising edge
// - Output bit 1: low or high active
// - Bits 8-9 enable position window sources
// - Bit 10 enables OR of velocity violations
// - Bits 11-15 enable diagnostic sources
// - Input bits 24-26 select input function
// - Line two shares layout, defaults output
// - Directional check only from start toward end
// - Independent mode ignores window order; violation drives output
package vmic_pkg;

  // Object indices and sub-indices
  localparam logic [15:0] IDX_DYN_MON      = 16'h2025;
  localparam logic [15:0] IDX_VEL_STATUS   = 16'h2026;
  localparam logic [15:0] IDX_IO_ONE       = 16'h2050;
  localparam logic [15:0] IDX_IO_TWO       = 16'h2051;
  localparam logic [7:0]  SUB_NONE         = 8'h00;
  localparam logic [7:0]  SUB_DYN_CONFIG   = 8'h01;
  localparam logic [7:0]  SUB_DYN_LIMIT    = 8'h02;
  localparam logic [7:0]  SUB_DYN_HYST     = 8'h03;
  localparam logic [7:0]  SUB_DYN_START    = 8'h04;
  localparam logic [7:0]  SUB_DYN_END      = 8'h05;

  // Monitor configuration fields
  localparam int          MON_BIT_BELOW    = 0;
  localparam int          MON_BIT_DIRDEP   = 1;
  localparam int          MON_BIT_ENABLE   = 2;
  localparam logic [7:0]  MON_CFG_MASK     = 8'h07;

  // Velocity status fields
  localparam int          ST_BIT_MEAS_ERR  = 0;
  localparam int          ST_BIT_MOVING    = 1;
  localparam int          ST_BIT_NEGATIVE  = 2;
  localparam int          ST_BIT_VIOL_LSB  = 3;
  localparam int          ST_BIT_DYN_VIOL  = 7;
  localparam int          ST_BIT_ACT_LSB   = 8;
  localparam int          ST_BIT_DYN_ACT   = 12;

  // I/O configuration fields
  localparam int          IO_BIT_OUTPUT    = 0;
  localparam int          IO_BIT_ACTIVE    = 1;
  localparam int          IO_BIT_SRC_LSB   = 8;
  localparam int          IO_NUM_SRC       = 8;
  localparam int          IO_FUNC_LSB      = 24;
  localparam logic [31:0] IO_CFG_MASK      = 32'h0700_FF03;
  localparam logic [2:0]  IO_FUNC_NONE     = 3'h0;
  localparam logic [2:0]  IO_FUNC_TEACH    = 3'h1;
  localparam logic [2:0]  IO_FUNC_LASER    = 3'h2;

  // Reset values
  localparam logic [7:0]  RST_DYN_CONFIG   = 8'h00;
  localparam logic [15:0] RST_DYN_LIMIT    = 16'h0000;
  localparam logic [15:0] RST_DYN_HYST     = 16'h0064;
  localparam logic [31:0] RST_DYN_POS      = 32'h0000_0000;
  localparam logic [31:0] RST_IO_ONE       = 32'h0000_0000;
  localparam logic [31:0] RST_IO_TWO       = 32'h0000_0001;

  // Value ranges
  localparam logic [15:0] VEL_MAX          = 16'h4E20;
  localparam logic [31:0] POS_MAX          = 32'h000F_423F;
  localparam logic [31:0] POS_MIN          = 32'hFFF0_BDC1;

endpackage : vmic_pkg

// >>> hdl/vmic_top.sv
// Dynamic velocity monitor, velocity status word and two switching I/O lines
`timescale 1ns/100ps

module vmic_top (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // Object access port
  input  wire logic               obj_req,
  input  wire logic               obj_we,
  input  wire logic [15:0]        obj_index,
  input  wire logic [7:0]         obj_sub,
  input  wire logic [31:0]        obj_wdata,
  output logic                    obj_ack_q,
  output logic                    obj_abort_q,
  output logic [31:0]             obj_rdata_q,
  // Measurement from the sensor core
  input  wire logic [15:0]        speed,
  input  wire logic               speed_negative,
  input  wire logic               speed_meas_error,
  input  wire logic signed [31:0] position,
  // Fixed monitors and position windows
  input  wire logic [3:0]         mon_violation,
  input  wire logic [3:0]         mon_active,
  input  wire logic [1:0]         pos_window_out,
  // Diagnostics
  input  wire logic               low_intensity_warning,
  input  wire logic               temperature_range_warning,
  input  wire logic               laser_prefailure_warning,
  input  wire logic               implausible_value_error,
  input  wire logic               hardware_error,
  // Switching I/O pins
  input  wire logic [1:0]         io_pin_in,
  output logic [1:0]              io_pin_out_q,
  output logic [1:0]              io_pin_oe_q,
  // Input line functions
  output logic                    preset_teach_q,
  output logic                    laser_off_q,
  // Status word
  output logic [15:0]             velocity_status_q
);

  logic [7:0]         dyn_monitor_config_q;
  logic [15:0]        dyn_velocity_limit_q;
  logic [15:0]        dyn_velocity_hysteresis_q;
  logic signed [31:0] dyn_window_start_pos_q;
  logic signed [31:0] dyn_window_end_pos_q;
  logic [31:0]        io_line_one_config_q;
  logic [31:0]        io_line_two_config_q;
  logic [31:0]        io_cfg [2];
  logic [1:0]         io_sync1_q;
  logic [1:0]         io_sync2_q;
  logic [1:0]         io_prev_q;
  logic               dyn_viol_q;
  logic               dyn_active;
  logic               in_window;
  logic               dir_ok;
  logic               over_set;
  logic               under_set;
  logic               over_clear;
  logic               under_clear;
  logic [16:0]        lim_hi;
  logic [16:0]        lim_lo;
  logic [7:0]         event_src;
  logic [1:0]         line_event;
  logic [1:0]         edge_hit;
  logic [1:0]         level_hit;
  logic               wr_ok;
  logic               known;
  logic [31:0]        rdata;

  assign io_cfg[0] = io_line_one_config_q;
  assign io_cfg[1] = io_line_two_config_q;

  // Range check of a signed position value
  function automatic logic pos_in_range(input logic [31:0] v);
    pos_in_range = ($signed(v) <= $signed(vmic_pkg::POS_MAX)) &&
                   ($signed(v) >= $signed(vmic_pkg::POS_MIN));
  endfunction

  // Object decode: read value, existence and write legality
  always_comb
  begin
    rdata = 32'h0000_0000;
    known = 1'b1;
    wr_ok = 1'b0;
    if (obj_index == vmic_pkg::IDX_DYN_MON && obj_sub == vmic_pkg::SUB_DYN_CONFIG)
    begin
      rdata = {24'h00_0000, dyn_monitor_config_q};
      wr_ok = 1'b1;
    end
    else if (obj_index == vmic_pkg::IDX_DYN_MON && obj_sub == vmic_pkg::SUB_DYN_LIMIT)
    begin
      rdata = {16'h0000, dyn_velocity_limit_q};
      wr_ok = obj_wdata[31:16] == 16'h0000 && obj_wdata[15:0] <= vmic_pkg::VEL_MAX;
    end
    else if (obj_index == vmic_pkg::IDX_DYN_MON && obj_sub == vmic_pkg::SUB_DYN_HYST)
    begin
      rdata = {16'h0000, dyn_velocity_hysteresis_q};
      wr_ok = obj_wdata[31:16] == 16'h0000 && obj_wdata[15:0] <= vmic_pkg::VEL_MAX;
    end
    else if (obj_index == vmic_pkg::IDX_DYN_MON && obj_sub == vmic_pkg::SUB_DYN_START)
    begin
      rdata = dyn_window_start_pos_q;
      wr_ok = pos_in_range(obj_wdata);
    end
    else if (obj_index == vmic_pkg::IDX_DYN_MON && obj_sub == vmic_pkg::SUB_DYN_END)
    begin
      rdata = dyn_window_end_pos_q;
      wr_ok = pos_in_range(obj_wdata);
    end
    else if (obj_index == vmic_pkg::IDX_VEL_STATUS && obj_sub == vmic_pkg::SUB_NONE)
    begin
      rdata = {16'h0000, velocity_status_q};
    end
    else if (obj_index == vmic_pkg::IDX_IO_ONE && obj_sub == vmic_pkg::SUB_NONE)
    begin
      rdata = io_line_one_config_q;
      wr_ok = 1'b1;
    end
    else if (obj_index == vmic_pkg::IDX_IO_TWO && obj_sub == vmic_pkg::SUB_NONE)
    begin
      rdata = io_line_two_config_q;
      wr_ok = 1'b1;
    end
    else
    begin
      known = 1'b0;
    end
  end

  // Access answer one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      obj_ack_q   <= 1'b0;
      obj_abort_q <= 1'b0;
      obj_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      obj_ack_q   <= obj_req;
      obj_abort_q <= obj_req && (!known || (obj_we && !wr_ok));
      if (obj_req && !obj_we && known)
        obj_rdata_q <= rdata;
    end
  end

  // Configuration storage; reserved bits are kept at zero
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dyn_monitor_config_q      <= vmic_pkg::RST_DYN_CONFIG;
      dyn_velocity_limit_q      <= vmic_pkg::RST_DYN_LIMIT;
      dyn_velocity_hysteresis_q <= vmic_pkg::RST_DYN_HYST;
      dyn_window_start_pos_q    <= vmic_pkg::RST_DYN_POS;
      dyn_window_end_pos_q      <= vmic_pkg::RST_DYN_POS;
      io_line_one_config_q      <= vmic_pkg::RST_IO_ONE;
      io_line_two_config_q      <= vmic_pkg::RST_IO_TWO;
    end
    else if (obj_req && obj_we && known && wr_ok)
    begin
      if (obj_index == vmic_pkg::IDX_DYN_MON)
      begin
        case (obj_sub)
          vmic_pkg::SUB_DYN_CONFIG:
            dyn_monitor_config_q <= obj_wdata[7:0] & vmic_pkg::MON_CFG_MASK;
          vmic_pkg::SUB_DYN_LIMIT:  dyn_velocity_limit_q      <= obj_wdata[15:0];
          vmic_pkg::SUB_DYN_HYST:   dyn_velocity_hysteresis_q <= obj_wdata[15:0];
          vmic_pkg::SUB_DYN_START:  dyn_window_start_pos_q    <= obj_wdata;
          default:                  dyn_window_end_pos_q      <= obj_wdata;
        endcase
      end
      else if (obj_index == vmic_pkg::IDX_IO_ONE)
        io_line_one_config_q <= obj_wdata & vmic_pkg::IO_CFG_MASK;
      else
        io_line_two_config_q <= obj_wdata & vmic_pkg::IO_CFG_MASK;
    end
  end

  // Window membership and direction gating
  always_comb
  begin
    in_window = 1'b1;
    dir_ok    = 1'b1;
    if (dyn_window_start_pos_q != dyn_window_end_pos_q)
    begin
      // Window bounds taken in either order
      if (dyn_window_start_pos_q < dyn_window_end_pos_q)
        in_window = position >= dyn_window_start_pos_q && position <= dyn_window_end_pos_q;
      else
        in_window = position >= dyn_window_end_pos_q && position <= dyn_window_start_pos_q;
      if (dyn_monitor_config_q[vmic_pkg::MON_BIT_DIRDEP])
        dir_ok = speed_negative == (dyn_window_start_pos_q > dyn_window_end_pos_q);
    end
  end

  // A stationary target has no direction to match
  assign dyn_active = dyn_monitor_config_q[vmic_pkg::MON_BIT_ENABLE] && in_window &&
                      (dir_ok || speed == 16'h0000) && !speed_meas_error;

  // Hysteresis thresholds, saturating at zero below
  assign lim_hi = {1'b0, dyn_velocity_limit_q} + {1'b0, dyn_velocity_hysteresis_q};
  assign lim_lo = (dyn_velocity_limit_q >= dyn_velocity_hysteresis_q) ?
                  {1'b0, dyn_velocity_limit_q - dyn_velocity_hysteresis_q} : 17'h0_0000;

  assign over_set    = speed > dyn_velocity_limit_q;
  assign under_set   = speed < dyn_velocity_limit_q;
  assign over_clear  = {1'b0, speed} <= lim_lo;
  assign under_clear = {1'b0, speed} >= lim_hi;

  // Dynamic violation flag with hysteresis
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      dyn_viol_q <= 1'b0;
    else if (!dyn_active)
      dyn_viol_q <= 1'b0;
    else if (!dyn_monitor_config_q[vmic_pkg::MON_BIT_BELOW])
    begin
      if (over_set)
        dyn_viol_q <= 1'b1;
      else if (over_clear)
        dyn_viol_q <= 1'b0;
    end
    else
    begin
      if (under_set)
        dyn_viol_q <= 1'b1;
      else if (under_clear)
        dyn_viol_q <= 1'b0;
    end
  end

  // Velocity status word
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      velocity_status_q <= 16'h0000;
    else
    begin
      velocity_status_q <= 16'h0000;
      velocity_status_q[vmic_pkg::ST_BIT_MEAS_ERR] <= speed_meas_error;
      velocity_status_q[vmic_pkg::ST_BIT_MOVING]   <= speed != 16'h0000;
      velocity_status_q[vmic_pkg::ST_BIT_NEGATIVE] <= speed_negative;
      velocity_status_q[vmic_pkg::ST_BIT_VIOL_LSB +: 4] <= mon_violation;
      velocity_status_q[vmic_pkg::ST_BIT_DYN_VIOL] <= dyn_viol_q;
      velocity_status_q[vmic_pkg::ST_BIT_ACT_LSB +: 4] <= mon_active;
      velocity_status_q[vmic_pkg::ST_BIT_DYN_ACT]  <= dyn_active;
    end
  end

  // Event sources in configuration bit order 8 to 15
  assign event_src = {hardware_error, implausible_value_error, laser_prefailure_warning,
                      temperature_range_warning, low_intensity_warning,
                      (|mon_violation) || dyn_viol_q,
                      pos_window_out};

  // Pin synchronisers; stage one feeds only stage two
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io_sync1_q <= 2'h0;
      io_sync2_q <= 2'h0;
      io_prev_q  <= 2'h0;
    end
    else
    begin
      io_sync1_q <= io_pin_in;
      io_sync2_q <= io_sync1_q;
      io_prev_q  <= io_sync2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_line
      assign line_event[g] = |(event_src &
                               io_cfg[g][vmic_pkg::IO_BIT_SRC_LSB +: vmic_pkg::IO_NUM_SRC]);
      // Active edge and active level per line
      assign edge_hit[g]   = io_cfg[g][vmic_pkg::IO_BIT_ACTIVE] ?
                             (io_sync2_q[g] && !io_prev_q[g]) : (!io_sync2_q[g] && io_prev_q[g]);
      assign level_hit[g]  = io_sync2_q[g] == io_cfg[g][vmic_pkg::IO_BIT_ACTIVE];
    end
  endgenerate

  // One process owns both pin vectors, so each has a single driver
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io_pin_out_q <= 2'h0;
      io_pin_oe_q  <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        io_pin_oe_q[i]  <= io_cfg[i][vmic_pkg::IO_BIT_OUTPUT];
        io_pin_out_q[i] <= io_cfg[i][vmic_pkg::IO_BIT_ACTIVE] ? line_event[i] :
                           !line_event[i];
      end
    end
  end

  // Input line functions; either line may request them
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      preset_teach_q <= 1'b0;
      laser_off_q    <= 1'b0;
    end
    else
    begin
      preset_teach_q <= 1'b0;
      laser_off_q    <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        if (!io_cfg[i][vmic_pkg::IO_BIT_OUTPUT])
        begin
          if (io_cfg[i][vmic_pkg::IO_FUNC_LSB +: 3] == vmic_pkg::IO_FUNC_TEACH && edge_hit[i])
            preset_teach_q <= 1'b1;
          // Laser stays off while the line holds its active level
          if (io_cfg[i][vmic_pkg::IO_FUNC_LSB +: 3] == vmic_pkg::IO_FUNC_LASER && level_hit[i])
            laser_off_q <= 1'b1;
        end
      end
    end
  end

endmodule // vmic_top

// >>> sim/vmic_properties.sv
// Port-level assertions for the velocity monitor and switching I/O block
`timescale 1ns/100ps

module vmic_properties (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Object port
  input wire logic        obj_req,
  input wire logic        obj_we,
  input wire logic [15:0] obj_index,
  input wire logic        obj_ack_q,
  input wire logic        obj_abort_q,
  // Measurement and monitors
  input wire logic [15:0] speed,
  input wire logic        speed_negative,
  input wire logic        speed_meas_error,
  input wire logic [3:0]  mon_violation,
  input wire logic [3:0]  mon_active,
  // Outputs
  input wire logic [1:0]  io_pin_oe_q,
  input wire logic        preset_teach_q,
  input wire logic [15:0] velocity_status_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  meas_err_flag_a: assert property (
    1'b1 |=> velocity_status_q[0] == $past(speed_meas_error))
    else $error("measurement error bit wrong");
  moving_flag_a: assert property (
    1'b1 |=> velocity_status_q[1] == ($past(speed) != 16'h0))
    else $error("moving bit wrong");
  direction_flag_a: assert property ($rose(speed_negative) |=> velocity_status_q[2])
    else $error("direction bit wrong");
  fixed_viol_copy_a: assert property (
    mon_violation != 4'h0 |=> velocity_status_q[6:3] == $past(mon_violation))
    else $error("fixed violation bits wrong");
  fixed_active_copy_a: assert property (
    1'b1 |=> velocity_status_q[11:8] == $past(mon_active))
    else $error("comparison active bits wrong");
  dyn_idle_clear_a: assert property (!velocity_status_q[12] |=> !velocity_status_q[7])
    else $error("dynamic flag set while idle");
  err_stops_dyn_a: assert property (speed_meas_error |=> !velocity_status_q[12])
    else $error("dynamic compare active on bad measurement");
  // Config lands one edge after the request, the enable one edge later
  oe_by_write_a: assert property (
    $past(rst_b, 2) && $changed(io_pin_oe_q) |->
    $past(obj_req && obj_we && obj_index[15:1] == 15'h1028, 2))
    else $error("line direction changed without write");
  teach_pulse_a: assert property (preset_teach_q |=> !preset_teach_q)
    else $error("teach pulse too long");

  cover property (velocity_status_q[7]);
  cover property (preset_teach_q);
  cover property (obj_ack_q && obj_abort_q);
endmodule // vmic_properties

bind vmic_top vmic_properties u_props (.ref_clk, .rst_b, .obj_req, .obj_we, .obj_index,
  .obj_ack_q, .obj_abort_q, .speed, .speed_negative, .speed_meas_error, .mon_violation,
  .mon_active, .io_pin_oe_q, .preset_teach_q, .velocity_status_q);

// >>> sim/vmic_master.sv
// Fieldbus master model issuing object reads and writes
`timescale 1ns/100ps

module vmic_master (
  // Clock
  input  wire logic ref_clk,
  // Object port
  output logic        obj_req,
  output logic        obj_we,
  output logic [15:0] obj_index,
  output logic [7:0]  obj_sub,
  output logic [31:0] obj_wdata
);
  initial
  begin
    {obj_req, obj_we, obj_index, obj_sub, obj_wdata} = '0;
  end

  task automatic xfer(input logic we, input logic [15:0] ix, input logic [7:0] sb,
                      input logic [31:0] d);
    @(negedge ref_clk);
    obj_req   = 1'b1;
    obj_we    = we;
    obj_index = ix;
    obj_sub   = sb;
    obj_wdata = d;
    @(negedge ref_clk);
    obj_req   = 1'b0;
    // Released bus carries garbage, never the last value
    obj_we    = ~we;
    obj_index = ~ix;
    obj_sub   = ~sb;
    obj_wdata = ~d;
  endtask
endmodule // vmic_master

// >>> sim/tb_velocity_monitor_io_config.sv
// Self-checking bench for the velocity monitor and switching I/O block
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end

module tb_velocity_monitor_io_config;
  logic               ref_clk, rst_b, obj_req, obj_we, obj_ack_q, obj_abort_q, hit;
  logic [15:0]        obj_index, speed, velocity_status_q;
  logic [7:0]         obj_sub;
  logic [31:0]        obj_wdata, obj_rdata_q;
  logic               speed_negative, speed_meas_error, preset_teach_q, laser_off_q;
  logic signed [31:0] position;
  logic [3:0]         mon_violation, mon_active;
  logic [1:0]         pos_window_out, io_pin_in, io_pin_out_q, io_pin_oe_q;
  logic               low_intensity_warning, temperature_range_warning, laser_prefailure_warning;
  logic               implausible_value_error, hardware_error;
  logic [33:0]        x;
  logic [33:0]        expq[$];
  logic [56:0]        wt[10];
  logic [24:0]        dt[7];
  int                 n_fail, compares;

  vmic_master u_mst (.ref_clk, .obj_req, .obj_we, .obj_index, .obj_sub, .obj_wdata);
  vmic_top u_dut (.ref_clk, .rst_b, .obj_req, .obj_we, .obj_index, .obj_sub, .obj_wdata,
    .obj_ack_q, .obj_abort_q, .obj_rdata_q, .speed, .speed_negative, .speed_meas_error,
    .position, .mon_violation, .mon_active, .pos_window_out, .low_intensity_warning,
    .temperature_range_warning, .laser_prefailure_warning, .implausible_value_error,
    .hardware_error, .io_pin_in, .io_pin_out_q, .io_pin_oe_q, .preset_teach_q, .laser_off_q,
    .velocity_status_q);

  function automatic logic [15:0] est(input logic a, input logic v);
    return {3'h0, a, mon_active, v, mon_violation, speed_negative, speed != 16'h0,
            speed_meas_error};
  endfunction

  task automatic acc(input logic we, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] d, input logic ab, input logic [31:0] e);
    expq.push_back({~we, ab, e});
    u_mst.xfer(we, ix, sb, d);
  endtask

  task automatic step(input logic [7:0] c, input logic [15:0] s, input logic n, a, v);
    acc(1'b1, 16'h2025, 8'h01, {24'h0, c}, 1'b0, '0);
    speed = s;
    speed_negative = n;
    repeat (3) @(negedge ref_clk);
    `CHK(velocity_status_q, est(a, v))
  endtask

  task automatic drv(input logic [7:0] s);
    {hardware_error, implausible_value_error, laser_prefailure_warning,
     temperature_range_warning, low_intensity_warning, mon_violation[0], pos_window_out} = s;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic seek(output logic h);
    h = 1'b0;
    repeat (8)
    begin
      @(posedge ref_clk);
      #1;
      if (preset_teach_q === 1'b1) h = 1'b1;
    end
    @(negedge ref_clk);
  endtask

  task automatic end_sim;
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Answers are matched in request order
  always @(posedge ref_clk)
  begin
    #1;
    if (obj_ack_q === 1'b1 && expq.size() > 0)
    begin
      x = expq.pop_front();
      `CHK(obj_abort_q, x[32])
      if (x[33]) `CHK(obj_rdata_q, x[31:0])
    end
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial
  begin
    {rst_b, speed, speed_negative, speed_meas_error, position, pos_window_out, io_pin_in} = '0;
    {low_intensity_warning, temperature_range_warning, laser_prefailure_warning} = '0;
    {implausible_value_error, hardware_error, n_fail, compares} = '0;
    void'($urandom(41608));
    mon_violation = 4'($urandom);
    mon_active = 4'($urandom);
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 7; i++)
      acc(1'b0, i < 5 ? 16'h2025 : 16'h2050 + 16'(i - 5), i < 5 ? 8'(i + 1) : 8'h00, '0,
          1'b0, i == 2 ? 32'h64 : 32'(i == 6));
    wt = '{{16'h2026, 8'h00, 32'h0, 1'b1}, {16'h2030, 8'h00, 32'h0, 1'b1},
           {16'h2025, 8'h02, 32'h4E21, 1'b1}, {16'h2025, 8'h02, 32'h4E20, 1'b0},
           {16'h2025, 8'h02, 32'h3E8, 1'b0}, {16'h2025, 8'h04, 32'hFFF0BDC0, 1'b1},
           {16'h2025, 8'h04, 32'hFFF0BDC1, 1'b0}, {16'h2025, 8'h01, 32'hFF, 1'b0},
           {16'h2025, 8'h05, 32'h0, 1'b0}, {16'h2025, 8'h00, 32'h0, 1'b1}};
    foreach (wt[i]) acc(1'b1, wt[i][56:41], wt[i][40:33], wt[i][32:1], wt[i][0], '0);
    acc(1'b0, 16'h2025, 8'h01, '0, 1'b0, 32'h7);
    acc(1'b0, 16'h2025, 8'h04, '0, 1'b0, 32'hFFF0BDC1);
    acc(1'b1, 16'h2025, 8'h04, 32'h0, 1'b0, '0);
    dt = '{{8'h04, 16'h3E9, 1'b1}, {8'h04, 16'h3B6, 1'b1}, {8'h04, 16'h384, 1'b0},
           {8'h00, 16'h3E9, 1'b0}, {8'h05, 16'h3E7, 1'b1}, {8'h05, 16'h41A, 1'b1},
           {8'h05, 16'h44C, 1'b0}};
    foreach (dt[i]) step(dt[i][24:17], dt[i][16:1], 1'b0, dt[i][19], dt[i][0]);
    acc(1'b1, 16'h2025, 8'h04, 32'h64, 1'b0, '0);
    acc(1'b1, 16'h2025, 8'h05, 32'hC8, 1'b0, '0);
    position = 32'sd150;
    step(8'h06, 16'h7D0, 1'b1, 1'b0, 1'b0);
    step(8'h06, 16'h7D0, 1'b0, 1'b1, 1'b1);
    position = 32'sd300;
    step(8'h06, 16'h7D0, 1'b0, 1'b0, 1'b0);
    position = 32'sd150;
    speed_meas_error = 1'b1;
    step(8'h04, 16'h7D0, 1'b0, 1'b0, 1'b0);
    speed_meas_error = 1'b0;
    step(8'h04, 16'h7D0, 1'b1, 1'b1, 1'b1);
    acc(1'b0, 16'h2026, 8'h00, '0, 1'b0, est(1'b1, 1'b1));
    step(8'h00, 16'h0, 1'b0, 1'b0, 1'b0);
    mon_violation = 4'h0;
    for (int k = 0; k < 8; k++)
    begin
      acc(1'b1, 16'h2051, 8'h00, 32'h3 | (32'h100 << k), 1'b0, '0);
      drv(8'h1 << k);
      `CHK(io_pin_out_q[1], 1'b1)
      drv(~(8'h1 << k));
      `CHK(io_pin_out_q[1], 1'b0)
    end
    acc(1'b1, 16'h2051, 8'h00, 32'h0000_FF01, 1'b0, '0);
    drv(8'h00);
    `CHK(io_pin_out_q[1], 1'b1)
    drv(8'h04);
    `CHK(io_pin_out_q[1], 1'b0)
    `CHK(io_pin_oe_q, 2'b10)
    for (int e = 0; e < 2; e++)
    begin
      io_pin_in[0] = ~e[0];
      acc(1'b1, 16'h2050, 8'h00, 32'h0100_0000 | 32'(e << 1), 1'b0, '0);
      repeat (4) @(negedge ref_clk);
      io_pin_in[0] = e[0];
      seek(hit);
      `CHK(hit, 1'b1)
    end
    io_pin_in[0] = 1'b0;
    seek(hit);
    `CHK(hit, 1'b0)
    acc(1'b1, 16'h2050, 8'h00, 32'h0200_0002, 1'b0, '0);
    io_pin_in[0] = 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK(laser_off_q, 1'b1)
    io_pin_in[0] = 1'b0;
    repeat (5) @(negedge ref_clk);
    `CHK(laser_off_q, 1'b0)
    // Line one as high-active output on the velocity source, still raised
    acc(1'b1, 16'h2050, 8'h00, 32'h0000_0403, 1'b0, '0);
    repeat (2) @(negedge ref_clk);
    `CHK(io_pin_oe_q, 2'b11)
    `CHK(io_pin_out_q[0], 1'b1)
    `CHK(expq.size(), 0)
    end_sim();
  end
endmodule // tb_velocity_monitor_io_config
